// *** rtl/rcb_regbank.sv ***
/*
 * Regulator control register bank with plain register port, buck-three
 * voltage-stepping pacer and boost automatic-mode resolution.
 * Assumes a synchronous master, default values from configuration
 * memory presented at otp_*_in and sampled while reset is high.
 */
// Overview of operation
// - Buck-three sleep register bits 4:0 hold sleep voltage code.
// - Buck-three mode bit 5 picks off or sleep after turn-off.
// - Buck-three mode bits 3:0 hold switching mode code.
// - Config bit 6: step 25 mV every 2 us (0) or 4 us (1).
// - Config bits 5:4 select switching clock phase.
// - Config bits 3:2 select switching frequency.
// - Config bit 0: current limit 2.75 A (0) or 2.0 A (1).
// - Boost bits 6:5 set standby mode: off, PULSE_FREQUENCY_MODE, auto, skip.
// - Boost bits 3:2 set normal mode with same encoding.
// - Boost bits 1:0 select output voltage, 5.000 to 5.150 V.
// - Auto mode picks PULSE_FREQUENCY_MODE or skip from load current.
// - Boost runs auto mode when power-up sequence enables it outside standby.
// - Front-end bit 0 set keeps regulator out of low power.
// - DDR reference bit 0 enables the reference supply.
// - Always-on bits 2:0 set voltage; code 110 is 3.0 V.
// - Linear-one bit 7 picks off or sleep on button turn-off.
// - Linear-one bit 6 allows low-power mode in standby.
// - Linear-one bit 5 set turns it off during standby.
// - Linear-one bit 4 enables the regulator.
// - Linear-one bits 3:0 hold its output voltage code.
// - Registers accept reads and writes in any device state.
// - Reset loads implemented fields from configuration memory.
`timescale 1ns/100ps

module rcb_regbank (
    input  wire logic        clk_in,
    input  wire logic        srst_in,
    input  wire logic [7:0]  addr_in,
    input  wire logic [7:0]  wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic      [7:0]  rdata_out,
    input  wire logic [7:0]  otp_buck3_sleep_in,
    input  wire logic [7:0]  otp_buck3_mode_in,
    input  wire logic [7:0]  otp_buck3_conf_in,
    input  wire logic [7:0]  otp_boost_ctl_in,
    input  wire logic [7:0]  otp_front_ctl_in,
    input  wire logic [7:0]  otp_ddrref_ctl_in,
    input  wire logic [7:0]  otp_stby_ctl_in,
    input  wire logic [7:0]  otp_lin1_ctl_in,
    input  wire logic        standby_in,
    input  wire logic        sleep_in,
    input  wire logic        heavy_load_in,
    input  wire logic        seq_boost_en_in,
    output logic      [4:0]  buck_three_sleep_code_out,
    output logic             buck_three_turnoff_mode_out,
    output logic      [3:0]  buck_three_switch_select_out,
    output logic             buck_three_step_rate_out,
    output logic      [1:0]  buck_three_clock_phase_out,
    output logic      [1:0]  buck_three_frequency_out,
    output logic             buck_three_current_limit_out,
    output logic             buck_three_step_tick_out,
    output logic      [1:0]  boost_active_mode_out,
    output logic      [1:0]  boost_voltage_code_out,
    output logic             front_end_low_power_out,
    output logic             ddr_reference_enable_out,
    output logic      [2:0]  always_on_voltage_code_out,
    output logic             always_on_code_valid_out,
    output logic             linear_one_turnoff_mode_out,
    output logic             linear_one_low_power_out,
    output logic             linear_one_on_out,
    output logic      [3:0]  linear_one_voltage_code_out
);

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [7:0] b3_sleep_q;
    logic [7:0] b3_mode_q;
    logic [7:0] b3_conf_q;
    logic [7:0] bst_ctl_q;
    logic [7:0] fe_ctl_q;
    logic [7:0] ddr_ctl_q;
    logic [7:0] aon_ctl_q;
    logic [7:0] l1_ctl_q;
    logic [7:0] rdata_d;
    logic [7:0] status_d;
    logic [1:0] bst_sel_d;
    logic [1:0] bst_mode_d;
    logic [1:0] bst_mode_q;
    logic [9:0] step_cnt_q;
    logic [9:0] step_lim_d;
    logic       step_tick_q;

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    // load defaults
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            b3_sleep_q <= otp_buck3_sleep_in & rcb_pkg::BUCK3_SLEEP_MASK;
            b3_mode_q  <= otp_buck3_mode_in & rcb_pkg::BUCK3_MODE_MASK;
            b3_conf_q  <= otp_buck3_conf_in & rcb_pkg::BUCK3_CONF_MASK;
            bst_ctl_q  <= otp_boost_ctl_in & rcb_pkg::BOOST_CTL_MASK;
            fe_ctl_q   <= otp_front_ctl_in & rcb_pkg::FRONT_CTL_MASK;
            ddr_ctl_q  <= otp_ddrref_ctl_in & rcb_pkg::DDRREF_CTL_MASK;
            aon_ctl_q  <= otp_stby_ctl_in & rcb_pkg::STBY_CTL_MASK;
            l1_ctl_q   <= otp_lin1_ctl_in & rcb_pkg::LIN1_CTL_MASK;
        end else if (wr_in) begin
            case (addr_in)
                rcb_pkg::BUCK3_SLEEP_ADDR: begin
                    b3_sleep_q <= wdata_in & rcb_pkg::BUCK3_SLEEP_MASK;
                end
                rcb_pkg::BUCK3_MODE_ADDR: begin
                    b3_mode_q <= wdata_in & rcb_pkg::BUCK3_MODE_MASK;
                end
                rcb_pkg::BUCK3_CONF_ADDR: begin
                    b3_conf_q <= wdata_in & rcb_pkg::BUCK3_CONF_MASK;
                end
                rcb_pkg::BOOST_CTL_ADDR: begin
                    bst_ctl_q <= wdata_in & rcb_pkg::BOOST_CTL_MASK;
                end
                rcb_pkg::FRONT_CTL_ADDR: begin
                    fe_ctl_q <= wdata_in & rcb_pkg::FRONT_CTL_MASK;
                end
                rcb_pkg::DDRREF_CTL_ADDR: begin
                    ddr_ctl_q <= wdata_in & rcb_pkg::DDRREF_CTL_MASK;
                end
                rcb_pkg::STBY_CTL_ADDR: begin
                    aon_ctl_q <= wdata_in & rcb_pkg::STBY_CTL_MASK;
                end
                rcb_pkg::LIN1_CTL_ADDR: begin
                    l1_ctl_q <= wdata_in & rcb_pkg::LIN1_CTL_MASK;
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always_comb begin
        status_d = 8'h00;
        status_d[1:0] = bst_mode_q;
        status_d[2] = linear_one_on_out;
        status_d[3] = front_end_low_power_out;
        status_d[4] = always_on_code_valid_out;
        rdata_d = 8'h00;
        case (addr_in)
            rcb_pkg::BUCK3_SLEEP_ADDR: rdata_d = b3_sleep_q;
            rcb_pkg::BUCK3_MODE_ADDR:  rdata_d = b3_mode_q;
            rcb_pkg::BUCK3_CONF_ADDR:  rdata_d = b3_conf_q;
            rcb_pkg::BOOST_CTL_ADDR:   rdata_d = bst_ctl_q;
            rcb_pkg::FRONT_CTL_ADDR:   rdata_d = fe_ctl_q;
            rcb_pkg::DDRREF_CTL_ADDR:  rdata_d = ddr_ctl_q;
            rcb_pkg::STBY_CTL_ADDR:    rdata_d = aon_ctl_q;
            rcb_pkg::LIN1_CTL_ADDR:    rdata_d = l1_ctl_q;
            rcb_pkg::STATUS_ADDR:      rdata_d = status_d;
            default:                   rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rdata_out <= 8'h00;
        end else if (rd_in) begin
            rdata_out <= rdata_d;
        end else begin
            rdata_out <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Buck-three fields
    // ------------------------------------------------------------
    // sleep code
    assign buck_three_sleep_code_out = b3_sleep_q[rcb_pkg::B3_SLEEP_LSB +: 5];
    assign buck_three_turnoff_mode_out = b3_mode_q[rcb_pkg::B3_OMODE_BIT];
    assign buck_three_switch_select_out =
        b3_mode_q[rcb_pkg::B3_SWSEL_LSB +: 4];
    assign buck_three_step_rate_out = b3_conf_q[rcb_pkg::B3_STEP_BIT];
    assign buck_three_clock_phase_out = b3_conf_q[rcb_pkg::B3_PHASE_LSB +: 2];
    assign buck_three_frequency_out = b3_conf_q[rcb_pkg::B3_FREQ_LSB +: 2];
    assign buck_three_current_limit_out = b3_conf_q[rcb_pkg::B3_ILIM_BIT];

    // ------------------------------------------------------------
    // Voltage-stepping pacer
    // ------------------------------------------------------------
    // step period select
    assign step_lim_d = b3_conf_q[rcb_pkg::B3_STEP_BIT] ?
        10'(rcb_pkg::STEP_SLOW_CYC - 1) : 10'(rcb_pkg::STEP_FAST_CYC - 1);

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            step_cnt_q  <= 10'h000;
            step_tick_q <= 1'b0;
        end else if (step_cnt_q >= step_lim_d) begin
            step_cnt_q  <= 10'h000;
            step_tick_q <= 1'b1;
        end else begin
            step_cnt_q  <= step_cnt_q + 10'h001;
            step_tick_q <= 1'b0;
        end
    end
    assign buck_three_step_tick_out = step_tick_q;

    // ------------------------------------------------------------
    // Boost converter mode
    // ------------------------------------------------------------
    // standby or normal mode field select
    always_comb begin
        bst_sel_d = standby_in ? bst_ctl_q[rcb_pkg::BST_STBY_LSB +: 2] :
                                 bst_ctl_q[rcb_pkg::BST_NORM_LSB +: 2];
        bst_mode_d = bst_sel_d;
        if (seq_boost_en_in && !standby_in) begin
            bst_sel_d  = rcb_pkg::BST_AUTO;
        end
        if (bst_sel_d == rcb_pkg::BST_AUTO) begin
            bst_mode_d = heavy_load_in ? rcb_pkg::BST_SKIP : rcb_pkg::BST_PFM;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            bst_mode_q <= rcb_pkg::BST_OFF;
        end else begin
            bst_mode_q <= bst_mode_d;
        end
    end
    assign boost_active_mode_out = bst_mode_q;
    assign boost_voltage_code_out = bst_ctl_q[rcb_pkg::BST_VOLT_LSB +: 2];

    // ------------------------------------------------------------
    // Front end, DDR reference, always-on supply
    // ------------------------------------------------------------
    // low-power inhibit
    assign front_end_low_power_out =
        standby_in & ~fe_ctl_q[rcb_pkg::FE_INHIBIT_BIT];
    assign ddr_reference_enable_out = ddr_ctl_q[rcb_pkg::DDR_EN_BIT];
    assign always_on_voltage_code_out = aon_ctl_q[rcb_pkg::AON_VOLT_LSB +: 3];
    assign always_on_code_valid_out =
        (aon_ctl_q[rcb_pkg::AON_VOLT_LSB +: 3] == rcb_pkg::AON_VOLT_3V0);

    // ------------------------------------------------------------
    // Linear regulator one
    // ------------------------------------------------------------
    // turn-off choice
    assign linear_one_turnoff_mode_out = l1_ctl_q[rcb_pkg::L1_OMODE_BIT];
    assign linear_one_low_power_out =
        standby_in & l1_ctl_q[rcb_pkg::L1_LPWR_BIT];
    assign linear_one_on_out = l1_ctl_q[rcb_pkg::L1_EN_BIT] &
        ~(standby_in & l1_ctl_q[rcb_pkg::L1_STBY_BIT]) & ~sleep_in;
    assign linear_one_voltage_code_out = l1_ctl_q[rcb_pkg::L1_VOLT_LSB +: 4];

endmodule

// *** rtl/rcb_pkg.sv ***
/*
 * Package for the regulator control register bank: register indices,
 * field positions and widths, mode encodings and timing constants.
 * Assumes one 100 MHz clock shared by the bank and its users.
 */
package rcb_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address on the plain port)
    // ------------------------------------------------------------
    localparam int          ADDR_W           = 8;
    localparam int          DATA_W           = 8;
    localparam logic [7:0]  BUCK3_SLEEP_ADDR = 8'h00;
    localparam logic [7:0]  BUCK3_MODE_ADDR  = 8'h01;
    localparam logic [7:0]  BUCK3_CONF_ADDR  = 8'h02;
    localparam logic [7:0]  BOOST_CTL_ADDR   = 8'h03;
    localparam logic [7:0]  FRONT_CTL_ADDR   = 8'h04;
    localparam logic [7:0]  DDRREF_CTL_ADDR  = 8'h05;
    localparam logic [7:0]  STBY_CTL_ADDR    = 8'h06;
    localparam logic [7:0]  LIN1_CTL_ADDR    = 8'h07;
    localparam logic [7:0]  STATUS_ADDR      = 8'h08;

    // ------------------------------------------------------------
    // Implemented-bit masks per register
    // ------------------------------------------------------------
    localparam logic [7:0]  BUCK3_SLEEP_MASK = 8'h1f;
    localparam logic [7:0]  BUCK3_MODE_MASK  = 8'h2f;
    localparam logic [7:0]  BUCK3_CONF_MASK  = 8'h7d;
    localparam logic [7:0]  BOOST_CTL_MASK   = 8'h6f;
    localparam logic [7:0]  FRONT_CTL_MASK   = 8'h01;
    localparam logic [7:0]  DDRREF_CTL_MASK  = 8'h01;
    localparam logic [7:0]  STBY_CTL_MASK    = 8'h07;
    localparam logic [7:0]  LIN1_CTL_MASK    = 8'hff;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int B3_SLEEP_LSB   = 0;
    localparam int B3_OMODE_BIT   = 5;
    localparam int B3_SWSEL_LSB   = 0;
    localparam int B3_STEP_BIT    = 6;
    localparam int B3_PHASE_LSB   = 4;
    localparam int B3_FREQ_LSB    = 2;
    localparam int B3_ILIM_BIT    = 0;
    localparam int BST_STBY_LSB   = 5;
    localparam int BST_NORM_LSB   = 2;
    localparam int BST_VOLT_LSB   = 0;
    localparam int FE_INHIBIT_BIT = 0;
    localparam int DDR_EN_BIT     = 0;
    localparam int AON_VOLT_LSB   = 0;
    localparam int L1_OMODE_BIT   = 7;
    localparam int L1_LPWR_BIT    = 6;
    localparam int L1_STBY_BIT    = 5;
    localparam int L1_EN_BIT      = 4;
    localparam int L1_VOLT_LSB    = 0;

    // ------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        BST_OFF  = 2'h0,
        BST_PFM  = 2'h1,
        BST_AUTO = 2'h2,
        BST_SKIP = 2'h3
    } rcb_boost_mode_t;

    localparam logic [2:0] AON_VOLT_3V0 = 3'h6;

    // ------------------------------------------------------------
    // Voltage-stepping timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ       = 100;
    localparam int STEP_FAST_NS  = 2000;
    localparam int STEP_SLOW_NS  = 4000;
    localparam int STEP_FAST_CYC = STEP_FAST_NS * CLK_MHZ / 1000;
    localparam int STEP_SLOW_CYC = STEP_SLOW_NS * CLK_MHZ / 1000;
    localparam int STEP_CNT_W    = 10;

endpackage

// *** testbench/rcb_regbank_chk.sv ***
/*
 * Checker for the regulator register bank: read port timing, status,
 * regulator outputs and buck-three step tick spacing.
 * Assumes binding onto rcb_regbank, one clock, synchronous reset.
 */
`timescale 1ns/100ps

module rcb_regbank_chk (
    input  wire logic        clk_in,
    input  wire logic        srst_in,
    input  wire logic [7:0]  addr_in,
    input  wire logic [7:0]  wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    input  wire logic [7:0]  rdata_out,
    input  wire logic        standby_in,
    input  wire logic        heavy_load_in,
    input  wire logic        seq_boost_en_in,
    input  wire logic        buck_three_step_rate_out,
    input  wire logic        buck_three_step_tick_out,
    input  wire logic [1:0]  boost_active_mode_out,
    input  wire logic        front_end_low_power_out,
    input  wire logic        ddr_reference_enable_out,
    input  wire logic [2:0]  always_on_voltage_code_out,
    input  wire logic        always_on_code_valid_out,
    input  wire logic        linear_one_on_out,
    input  wire logic        linear_one_low_power_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);

    // ------------------------------------------------------------
    // Tick spacing helper
    // ------------------------------------------------------------
    int   gap_q;
    logic seen_q;
    logic chg_q;
    logic rate_q;
    always_ff @(posedge clk_in) begin
        if (srst_in || buck_three_step_tick_out) begin
            gap_q  <= 1;
            seen_q <= !srst_in;
            chg_q  <= 1'b0;
            rate_q <= buck_three_step_rate_out;
        end else begin
            gap_q <= gap_q + 1;
            if (buck_three_step_rate_out != rate_q) begin
                chg_q <= 1'b1;
            end
        end
    end

    sequence s_lin1_stby_off;
        wr_in && addr_in == rcb_pkg::LIN1_CTL_ADDR && wdata_in[5];
    endsequence
    sequence s_status_rd;
        rd_in && addr_in == rcb_pkg::STATUS_ADDR;
    endsequence

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_rdata_idle_zero: assert property (!$past(rd_in)
        |-> rdata_out == 8'h00)
        else $error("read data not zero outside read answer");
    a_status_read: assert property (s_status_rd |=> rdata_out == {3'h0,
        $past(always_on_code_valid_out), $past(front_end_low_power_out),
        $past(linear_one_on_out), $past(boost_active_mode_out)})
        else $error("status read differs from outputs");
    a_unmapped_zero: assert property (rd_in && addr_in > 8'h08
        |=> rdata_out == 8'h00) else $error("unmapped read not zero");
    a_ddr_enable: assert property (wr_in && addr_in ==
        rcb_pkg::DDRREF_CTL_ADDR |=> ddr_reference_enable_out ==
        $past(wdata_in[0])) else $error("ddr enable not written");
    a_front_inhibit: assert property (wr_in && addr_in ==
        rcb_pkg::FRONT_CTL_ADDR && wdata_in[0] |=> !front_end_low_power_out)
        else $error("front end low power while inhibited");
    a_front_only_stby: assert property (front_end_low_power_out |->
        standby_in) else $error("front end low power outside standby");
    a_lin1_stby_off: assert property (s_lin1_stby_off ##1 standby_in
        |-> !linear_one_on_out) else $error("linear one on in standby");
    a_lin1_disable: assert property (wr_in && addr_in ==
        rcb_pkg::LIN1_CTL_ADDR && !wdata_in[4] |=> !linear_one_on_out)
        else $error("linear one on while disabled");
    a_lin1_lpwr_stby: assert property (linear_one_low_power_out |->
        standby_in) else $error("linear one low power outside standby");
    a_boost_auto_run: assert property (!srst_in && seq_boost_en_in
        && !standby_in |=> boost_active_mode_out ==
        ($past(heavy_load_in) ? 2'h3 : 2'h1))
        else $error("boost auto mode not resolved by load");
    a_aon_code_flag: assert property (always_on_code_valid_out ==
        (always_on_voltage_code_out == rcb_pkg::AON_VOLT_3V0))
        else $error("always-on valid flag wrong");
    a_tick_period: assert property (buck_three_step_tick_out && seen_q
        && !chg_q && buck_three_step_rate_out == rate_q
        |-> gap_q == (rate_q ? 400 : 200)) else $error("tick spacing wrong");
    a_tick_timely: assert property (gap_q <= 400)
        else $error("tick overdue");
endmodule

bind rcb_regbank rcb_regbank_chk chk_u (.clk_in(clk_in), .srst_in(srst_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .standby_in(standby_in),
    .heavy_load_in(heavy_load_in), .seq_boost_en_in(seq_boost_en_in),
    .buck_three_step_rate_out(buck_three_step_rate_out),
    .buck_three_step_tick_out(buck_three_step_tick_out),
    .boost_active_mode_out(boost_active_mode_out),
    .front_end_low_power_out(front_end_low_power_out),
    .ddr_reference_enable_out(ddr_reference_enable_out),
    .always_on_voltage_code_out(always_on_voltage_code_out),
    .always_on_code_valid_out(always_on_code_valid_out),
    .linear_one_on_out(linear_one_on_out),
    .linear_one_low_power_out(linear_one_low_power_out));

// *** testbench/rcb_regbank_test.sv ***
/*
 * Self-checking bench for rcb_regbank: register model, random access
 * under random device states, resets and step tick spacing.
 * Assumes the package and the checker are compiled before it.
 */
`timescale 1ns/100ps

module rcb_regbank_test;
    localparam logic [7:0] MSK [8] = '{rcb_pkg::BUCK3_SLEEP_MASK,
        rcb_pkg::BUCK3_MODE_MASK, rcb_pkg::BUCK3_CONF_MASK,
        rcb_pkg::BOOST_CTL_MASK, rcb_pkg::FRONT_CTL_MASK,
        rcb_pkg::DDRREF_CTL_MASK, rcb_pkg::STBY_CTL_MASK,
        rcb_pkg::LIN1_CTL_MASK};
    logic       clk_in, srst_in, wr_in, rd_in;
    logic       standby_in, sleep_in, heavy_load_in, seq_boost_en_in;
    logic [7:0] addr_in, wdata_in, rdata_out, otp [8], m [8], st_e;
    logic [7:0] a, v, d;
    logic [4:0] b3_slp;
    logic [3:0] b3_sw, l1_v;
    logic [2:0] aon_c;
    logic [1:0] b3_ph, b3_fq, bst_m, bst_v;
    logic       b3_om, b3_sr, b3_il, b3_tk, fe_lp, ddr_en, aon_ok;
    logic       l1_om, l1_lp, l1_on;
    int         fails, total_checks, n;
    integer     seed = 46771;

    rcb_regbank dut_u (.clk_in(clk_in), .srst_in(srst_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
        .rd_in(rd_in), .rdata_out(rdata_out),
        .otp_buck3_sleep_in(otp[0]), .otp_buck3_mode_in(otp[1]),
        .otp_buck3_conf_in(otp[2]), .otp_boost_ctl_in(otp[3]),
        .otp_front_ctl_in(otp[4]), .otp_ddrref_ctl_in(otp[5]),
        .otp_stby_ctl_in(otp[6]), .otp_lin1_ctl_in(otp[7]),
        .standby_in(standby_in), .sleep_in(sleep_in),
        .heavy_load_in(heavy_load_in), .seq_boost_en_in(seq_boost_en_in),
        .buck_three_sleep_code_out(b3_slp),
        .buck_three_turnoff_mode_out(b3_om),
        .buck_three_switch_select_out(b3_sw),
        .buck_three_step_rate_out(b3_sr),
        .buck_three_clock_phase_out(b3_ph),
        .buck_three_frequency_out(b3_fq),
        .buck_three_current_limit_out(b3_il),
        .buck_three_step_tick_out(b3_tk), .boost_active_mode_out(bst_m),
        .boost_voltage_code_out(bst_v), .front_end_low_power_out(fe_lp),
        .ddr_reference_enable_out(ddr_en),
        .always_on_voltage_code_out(aon_c),
        .always_on_code_valid_out(aon_ok),
        .linear_one_turnoff_mode_out(l1_om),
        .linear_one_low_power_out(l1_lp), .linear_one_on_out(l1_on),
        .linear_one_voltage_code_out(l1_v));

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Bus and reset tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
        @(posedge clk_in);
        wr_in <= 1'b1;
        addr_in <= ad;
        wdata_in <= dt;
        @(posedge clk_in);
        wr_in <= 1'b0;
        if (ad < 8) m[ad[2:0]] = dt & MSK[ad[2:0]];
    endtask

    task automatic rd(input logic [7:0] ad, output logic [7:0] dt);
        @(posedge clk_in);
        rd_in <= 1'b1;
        addr_in <= ad;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 dt = rdata_out;
    endtask

    task automatic do_reset;
        @(posedge clk_in);
        srst_in <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            v = $random(seed);
            otp[i] <= v;
            m[i] = v & MSK[i];
        end
        repeat (12) @(posedge clk_in);
        srst_in <= 1'b0;
        for (int i = 0; i < 8; i++) otp[i] <= $random(seed);
    endtask

    task automatic chk_outs;
        logic [1:0] bm;
        bm = standby_in ? m[3][6:5] : (seq_boost_en_in ? 2'h2 : m[3][3:2]);
        if (bm == 2'h2) bm = heavy_load_in ? 2'h3 : 2'h1;
        st_e = {3'h0, m[6][2:0] == 3'h6, standby_in & ~m[4][0],
            m[7][4] & ~(standby_in & m[7][5]) & ~sleep_in, bm};
        check({b3_slp, b3_om}, {m[0][4:0], m[1][5]});
        check(b3_sw, m[1][3:0]);
        check({b3_sr, b3_ph}, m[2][6:4]);
        check({b3_fq, b3_il}, {m[2][3:2], m[2][0]});
        check({bst_m, bst_v}, {bm, m[3][1:0]});
        check({fe_lp, ddr_en}, {standby_in & ~m[4][0], m[5][0]});
        check({aon_c, aon_ok}, {m[6][2:0], m[6][2:0] == 3'h6});
        check({l1_om, l1_lp}, {m[7][7], standby_in & m[7][6]});
        check({l1_on, l1_v}, {st_e[2], m[7][3:0]});
    endtask

    function automatic logic [7:0] ex(input logic [7:0] ad);
        return ad < 8 ? m[ad[2:0]] : (ad == 8 ? st_e : 8'h00);
    endfunction

    task automatic wait_tick(output int cnt);
        cnt = 0;
        do begin
            @(posedge clk_in);
            #1 cnt++;
        end while (b3_tk !== 1'b1 && cnt < 500);
        if (cnt >= 500) begin
            fails++;
            wrap_up;
        end
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {srst_in, wr_in, rd_in, addr_in, wdata_in} = '0;
        {standby_in, sleep_in, heavy_load_in, seq_boost_en_in} = '0;
        for (int i = 0; i < 8; i++) otp[i] = 8'h00;
        do_reset;
        for (int i = 0; i < 11; i++) begin
            rd(i[7:0], d);
            chk_outs;
            check(d, ex(i[7:0]));
        end
        for (int i = 0; i < 80; i++) begin
            @(posedge clk_in);
            {standby_in, sleep_in, heavy_load_in, seq_boost_en_in} <=
                $random(seed);
            a = $random(seed) & 8'h0f;
            wr(a, $random(seed));
            rd(a, d);
            chk_outs;
            check(d, ex(a));
            if (i == 40) do_reset;
        end
        for (int r = 0; r < 2; r++) begin
            wr(rcb_pkg::BUCK3_CONF_ADDR, r ? 8'h40 : 8'h00);
            wait_tick(n);
            wait_tick(n);
            check(16'(n), r ? 16'd400 : 16'd200);
        end
        wrap_up;
    end
endmodule
